//--- design/relay_board_status_watchdog.sv
// Relay board drivers, status indicators and heartbeat safety watchdog.
// Functional notes
// R1 - CPU toggles heartbeat every three seconds.
// R2 - Heartbeat unchanged thirty seconds declares failure.
// R3 - Failure forces valves, UV and heaters off.
// R4 - Failure leaves the sample pump running.
// R5 - Heater indicators lit while heater energized.
// R6 - Zero/span indicator lit when zero selected.
// R7 - Sample/cal indicator lit when cal routed.
// R8 - Relays and valves commanded by CPU writes.
// R9 - Timer restarts on edge; failure latches.
`timescale 1ns/1ps
`default_nettype none

module relay_board_status_watchdog #(
    parameter int unsigned FAIL_CYCLES = relay_wd_pkg::FAIL_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [relay_wd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [relay_wd_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [relay_wd_pkg::DATA_W-1:0] o_rdata,
    output relay_wd_pkg::ctrl_t o_drive,
    output logic [relay_wd_pkg::LED_COUNT-1:0] o_leds,
    output logic o_fail,
    output logic o_irq
);

    // Last count value before the failure is declared.
    localparam logic [31:0] LIMIT = 32'(FAIL_CYCLES - 1);

    // Maps the effective drive word onto the indicator bank.
    function automatic logic [relay_wd_pkg::LED_COUNT-1:0] led_map(
        input relay_wd_pkg::ctrl_t d
    );
        logic [relay_wd_pkg::LED_COUNT-1:0] l;
        l = '0;
        l[relay_wd_pkg::IDX_HEARTBEAT_INDICATOR] = d.heartbeat;
        // Heating indicators follow the energized heaters. [R5]
        l[relay_wd_pkg::IDX_CHAMBER_HEAT_INDICATOR] = d.heat_chamber;
        l[relay_wd_pkg::IDX_CONVERTER_HEAT_INDICATOR] = d.heat_conv;
        l[relay_wd_pkg::IDX_PERM_TUBE_HEAT_INDICATOR] = d.heat_perm;
        // A set bit routes the valve to the cal path. [R7]
        l[relay_wd_pkg::IDX_SAMPLE_CAL_VALVE_INDICATOR] = d.valve_sample_cal;
        // A set bit selects the zero gas inlet. [R6]
        l[relay_wd_pkg::IDX_ZERO_SPAN_VALVE_INDICATOR] = d.valve_zero_span;
        l[relay_wd_pkg::IDX_SO2_VALVE_INDICATOR] = d.valve_so2;
        l[relay_wd_pkg::IDX_LAMP_SHUTTER_INDICATOR] = d.shutter;
        return l;
    endfunction

    // Command word as written by software.
    relay_wd_pkg::ctrl_t ctrl_q;
    // Heartbeat level seen one cycle earlier.
    logic beat_prev_q;
    // Cycles since the last heartbeat change, saturating at LIMIT.
    logic [31:0] cnt_q;
    // Latched controller failure.
    logic fail_q;
    // Sticky interrupt status and its mask.
    logic [relay_wd_pkg::IRQ_W-1:0] irq_stat_q;
    logic [relay_wd_pkg::IRQ_W-1:0] irq_mask_q;
    // Registered outputs.
    relay_wd_pkg::ctrl_t drive_q;
    logic [relay_wd_pkg::LED_COUNT-1:0] leds_q;
    logic [relay_wd_pkg::DATA_W-1:0] rdata_q;
    logic irq_q;

    // Decoded write strobes.
    logic wr_ctrl;
    logic wr_irq_stat;
    logic wr_irq_mask;
    // Heartbeat transition and timeout detection.
    logic beat_edge;
    logic fail_hit;
    // Effective drive word after the safety override.
    relay_wd_pkg::ctrl_t drive_d;
    // Interrupt events of this cycle.
    logic [relay_wd_pkg::IRQ_W-1:0] irq_ev;

    // Write decode.
    always_comb begin
        wr_ctrl = i_wr && (i_addr == relay_wd_pkg::ADDR_CTRL);
        wr_irq_stat = i_wr && (i_addr == relay_wd_pkg::ADDR_IRQ_STAT);
        wr_irq_mask = i_wr && (i_addr == relay_wd_pkg::ADDR_IRQ_MASK);
    end

    // Command register; software switches relays and valves here. [R8]
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q <= relay_wd_pkg::ctrl_t'(relay_wd_pkg::CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl_q <= relay_wd_pkg::ctrl_t'(
                i_wdata[relay_wd_pkg::CTRL_W-1:0]);
        end
    end

    // The CPU proves it is alive by toggling this bit. [R1]
    always_comb begin
        beat_edge = ctrl_q.heartbeat ^ beat_prev_q;
        // Timeout when the level held through the full window. [R2]
        fail_hit = !beat_edge && (cnt_q == LIMIT);
    end

    // Previous heartbeat level for edge detection.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            beat_prev_q <= 1'b0;
        end else begin
            beat_prev_q <= ctrl_q.heartbeat;
        end
    end

    // Failure timer; any heartbeat change restarts it. [R9]
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 32'h0000_0000;
        end else if (beat_edge) begin
            cnt_q <= 32'h0000_0000;
        end else if (cnt_q < LIMIT) begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    // Failure latch; only reset releases it. [R9]
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fail_q <= 1'b0;
        end else if (fail_hit) begin
            fail_q <= 1'b1; // [R2]
        end
    end

    // Safety override applied on the cycle of the timeout as well.
    always_comb begin
        drive_d = ctrl_q;
        if (fail_q || fail_hit) begin
            // Valves, UV source and heaters are forced off. [R3]
            drive_d.valve_so2 = 1'b0;
            drive_d.valve_zero_span = 1'b0;
            drive_d.valve_sample_cal = 1'b0;
            drive_d.uv_lamp = 1'b0;
            drive_d.heat_chamber = 1'b0;
            drive_d.heat_conv = 1'b0;
            drive_d.heat_perm = 1'b0;
            // The pump bit is left alone so sampling continues. [R4]
        end
    end

    // Output drivers and indicators are registered together.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            drive_q <= relay_wd_pkg::ctrl_t'(relay_wd_pkg::CTRL_RESET);
            leds_q <= '0;
        end else begin
            drive_q <= drive_d;
            leds_q <= led_map(drive_d); // [R5]
        end
    end

    // Events: new failure and each heartbeat change.
    always_comb begin
        irq_ev = '0;
        irq_ev[relay_wd_pkg::IRQ_FAIL_BIT] = fail_hit && !fail_q;
        irq_ev[relay_wd_pkg::IRQ_BEAT_BIT] = beat_edge;
    end

    // Sticky status, write one to clear; a new event wins the clear.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat_q <= relay_wd_pkg::IRQ_RESET;
        end else if (wr_irq_stat) begin
            irq_stat_q <= (irq_stat_q
                & ~i_wdata[relay_wd_pkg::IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    // Interrupt mask, a set bit enables the event.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_mask_q <= relay_wd_pkg::IRQ_RESET;
        end else if (wr_irq_mask) begin
            irq_mask_q <= i_wdata[relay_wd_pkg::IRQ_W-1:0];
        end
    end

    // Level interrupt, one cycle behind the status bits.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= '0;
        end else if (!i_rd) begin
            rdata_q <= '0;
        end else if (i_addr == relay_wd_pkg::ADDR_CTRL) begin
            rdata_q <= {22'h0, ctrl_q};
        end else if (i_addr == relay_wd_pkg::ADDR_STATUS) begin
            rdata_q <= '0;
            rdata_q[relay_wd_pkg::STAT_FAIL_BIT] <= fail_q;
            rdata_q[relay_wd_pkg::STAT_BEAT_BIT] <= ctrl_q.heartbeat;
        end else if (i_addr == relay_wd_pkg::ADDR_IRQ_STAT) begin
            rdata_q <= {30'h0, irq_stat_q};
        end else if (i_addr == relay_wd_pkg::ADDR_IRQ_MASK) begin
            rdata_q <= {30'h0, irq_mask_q};
        end else if (i_addr == relay_wd_pkg::ADDR_TIMER) begin
            rdata_q <= cnt_q;
        end else begin
            // Unmapped addresses read as zero.
            rdata_q <= '0;
        end
    end

    // Ports come straight from flip-flops.
    assign o_rdata = rdata_q;
    assign o_drive = drive_q;
    assign o_leds = leds_q;
    assign o_fail = fail_q;
    assign o_irq = irq_q;

    // Checks below share the one clock and its reset.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // A full quiet window must raise the failure next cycle.
    a_fail_on_timeout: assert property ( // [R2]
        (!beat_edge && cnt_q == LIMIT) |=> fail_q
    ) else $error("failure not declared after heartbeat timeout");

    // Failure may only rise after a full quiet window.
    a_no_early_fail: assert property ( // [R2]
        $rose(fail_q) |-> ($past(cnt_q) == LIMIT && !$past(beat_edge))
    ) else $error("failure declared before the window ran out");

    // A heartbeat change clears the timer, or else failure is already set.
    a_timer_restart: assert property ( // [R9]
        beat_edge |=> (cnt_q == 32'h0000_0000) || fail_q
    ) else $error("failure timer not restarted by heartbeat edge");

    a_fail_latched: assert property ( // [R9]
        fail_q |=> fail_q
    ) else $error("failure latch released without reset");

    // Forced outputs are off while failed.
    a_forced_off: assert property ( // [R3]
        fail_q |=> !(o_drive.valve_so2 || o_drive.valve_zero_span
            || o_drive.valve_sample_cal || o_drive.uv_lamp
            || o_drive.heat_chamber || o_drive.heat_conv
            || o_drive.heat_perm)
    ) else $error("valve, lamp or heater on during failure");

    // The pump still follows its command while failed.
    a_pump_kept: assert property ( // [R4]
        fail_q |=> (o_drive.pump == $past(ctrl_q.pump))
    ) else $error("pump disturbed by failure shutdown");

    // Heating indicators match the heater drives.
    a_heat_leds: assert property ( // [R5]
        o_leds[relay_wd_pkg::IDX_CHAMBER_HEAT_INDICATOR]
            == o_drive.heat_chamber
        && o_leds[relay_wd_pkg::IDX_CONVERTER_HEAT_INDICATOR]
            == o_drive.heat_conv
        && o_leds[relay_wd_pkg::IDX_PERM_TUBE_HEAT_INDICATOR]
            == o_drive.heat_perm
    ) else $error("heater indicator disagrees with heater");

    a_zero_span_led: assert property ( // [R6]
        ##1 o_leds[relay_wd_pkg::IDX_ZERO_SPAN_VALVE_INDICATOR]
            == $past(drive_d.valve_zero_span)
    ) else $error("zero/span indicator wrong");

    a_sample_cal_led: assert property ( // [R7]
        ##1 o_leds[relay_wd_pkg::IDX_SAMPLE_CAL_VALVE_INDICATOR]
            == $past(drive_d.valve_sample_cal)
    ) else $error("sample/cal indicator wrong");

    // A command write reaches the drives two cycles later.
    a_cmd_write: assert property ( // [R8]
        (wr_ctrl && !fail_q && !fail_hit) ##1 !fail_hit
            |=> (o_drive.pump == $past(i_wdata[9], 2))
    ) else $error("pump command not applied");

    c_failure: cover property ($rose(fail_q));
    // Two heartbeat changes close enough to keep the board alive.
    c_beat: cover property (beat_edge ##[1:300] beat_edge);
    c_irq: cover property ($rose(o_irq));
    // Software keeps writing commands after the shutdown latched.
    c_forced_write: cover property (fail_q && wr_ctrl);

endmodule // relay_board_status_watchdog

`default_nettype wire

//--- design/relay_wd_pkg.sv
// Constants and types for the relay board status and watchdog block.
package relay_wd_pkg;
    // Clock rate and heartbeat failure time.
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned FAIL_TIME_MS = 30_000;
    localparam int unsigned FAIL_CYCLES = FAIL_TIME_MS * (CLK_HZ / 1000);

    // Register bus widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_TIMER = 8'h10;

    // Control word: one bit per relay, valve driver and indicator source.
    typedef struct packed {
        logic pump;
        logic shutter;
        logic uv_lamp;
        logic valve_so2;
        logic valve_zero_span;
        logic valve_sample_cal;
        logic heat_perm;
        logic heat_conv;
        logic heat_chamber;
        logic heartbeat;
    } ctrl_t;
    localparam int CTRL_W = 10;
    localparam logic [9:0] CTRL_RESET = 10'h000;

    // Interrupt bits.
    localparam int IRQ_W = 2;
    localparam int IRQ_FAIL_BIT = 0;
    localparam int IRQ_BEAT_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Status bits.
    localparam int STAT_FAIL_BIT = 0;
    localparam int STAT_BEAT_BIT = 1;

    // Indicator bank positions.
    localparam int LED_COUNT = 16;
    localparam int IDX_HEARTBEAT_INDICATOR = 0;
    localparam int IDX_CHAMBER_HEAT_INDICATOR = 1;
    localparam int IDX_CONVERTER_HEAT_INDICATOR = 2;
    localparam int IDX_PERM_TUBE_HEAT_INDICATOR = 4;
    localparam int IDX_SAMPLE_CAL_VALVE_INDICATOR = 6;
    localparam int IDX_ZERO_SPAN_VALVE_INDICATOR = 7;
    localparam int IDX_SO2_VALVE_INDICATOR = 8;
    localparam int IDX_LAMP_SHUTTER_INDICATOR = 10;
endpackage

//--- test/cpu_model.sv
// Register bus master model of the controlling processor.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    // The bus idles with both strobes low from time zero.
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // One write cycle; the data is scrambled once the strobe drops.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1; // Commands go out as writes.
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask

    // One read cycle; the data is taken at the edge after the one where the strobe drops.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(posedge i_clk);
        d = i_rdata;
    endtask

    // Toggles the heartbeat n times, gap plus two cycles apart, slow or prompt.
    task automatic beat(input logic [31:0] base, input int n, input int gap);
        logic [31:0] c;
        c = base;
        for (int k = 0; k < n; k++) begin
            c[0] = ~c[0];
            wr(relay_wd_pkg::ADDR_CTRL, c); // Alternate the beat.
            repeat (gap) @(posedge i_clk);
        end
    endtask
endmodule // cpu_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the relay board status watchdog.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int unsigned FC = 200; // Short failure time for simulation.
    localparam logic [7:0] A_CTRL = relay_wd_pkg::ADDR_CTRL;
    logic i_clk; // Board clock.
    logic i_rst; // Synchronous reset.
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    relay_wd_pkg::ctrl_t drive; // Effective relay drives.
    logic [15:0] leds; // Indicator bank.
    logic fail;
    logic irq;
    logic [31:0] v; // Last read result.
    int num_errors;
    int num_checks;

    relay_board_status_watchdog #(.FAIL_CYCLES(FC)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_drive(drive),
        .o_leds(leds), .o_fail(fail), .o_irq(irq));
    cpu_model cpu (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    // The clock toggles every 12.5 ns, half of its 25 ns period.
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Expected indicator bank for a control word.
    function automatic logic [15:0] led_of(input logic [9:0] c);
        led_of = {5'h00, c[8], 1'b0, c[6], c[5], c[4], 1'b0, c[3], 1'b0,
            c[2], c[1], c[0]};
    endfunction

    task automatic clk_n(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Holds reset for four cycles.
    task automatic do_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        clk_n(4);
        i_rst <= 1'b0;
    endtask

    // Walks one bit through the control word; unmapped access too.
    task automatic t_map;
        logic [9:0] c;
        do_reset();
        chk("drive rst", 32'h0, 32'(drive));
        chk("leds rst", 32'h0, 32'(leds));
        for (int b = 0; b < 10; b++) begin
            c = 10'h001 << b;
            cpu.wr(A_CTRL, 32'(c));
            clk_n(2);
            chk("drive", 32'(c), 32'(drive));
            chk("leds", 32'(led_of(c)), 32'(leds));
        end
        cpu.rd(A_CTRL, v);
        chk("ctrl", 32'h200, v);
        cpu.wr(8'h40, 32'hffffffff);
        cpu.rd(8'h40, v);
        chk("unmapped", 32'h0, v);
        cpu.rd(A_CTRL, v);
        chk("ctrl kept", 32'h200, v);
    endtask

    // Heartbeat event raises, clears and is masked off.
    task automatic t_irq;
        do_reset();
        cpu.wr(relay_wd_pkg::ADDR_IRQ_MASK, 32'h2);
        cpu.rd(relay_wd_pkg::ADDR_IRQ_MASK, v);
        chk("irq mask", 32'h2, v);
        cpu.wr(A_CTRL, 32'h1);
        clk_n(4);
        chk("irq raised", 32'h1, 32'(irq));
        cpu.rd(relay_wd_pkg::ADDR_IRQ_STAT, v);
        chk("beat event", 32'h2, v);
        cpu.wr(relay_wd_pkg::ADDR_IRQ_STAT, 32'h2);
        clk_n(4);
        chk("irq cleared", 32'h0, 32'(irq));
        cpu.wr(relay_wd_pkg::ADDR_IRQ_MASK, 32'h0);
        cpu.wr(A_CTRL, 32'h0);
        clk_n(4);
        chk("irq masked", 32'h0, 32'(irq));
    endtask

    // Slow but steady beats keep the board alive far past the limit.
    task automatic t_alive;
        do_reset();
        cpu.beat(32'h0, 8, FC - 10);
        chk("alive", 32'h0, 32'(fail));
        // The timer restarted on the last beat and has run since then.
        cpu.rd(relay_wd_pkg::ADDR_TIMER, v);
        chk("timer", 32'(FC - 10), v);
    endtask

    // A stopped beat trips, forces outputs off and stays latched.
    task automatic t_fail;
        int k;
        do_reset();
        cpu.wr(relay_wd_pkg::ADDR_IRQ_MASK, 32'h1);
        cpu.wr(A_CTRL, 32'h3ff);
        clk_n(FC - 20);
        chk("early", 32'h0, 32'(fail));
        k = 0;
        while (fail !== 1'b1 && k < 40) begin
            clk_n(1);
            k++;
        end
        if (k == 40) begin
            num_errors++;
            final_report();
        end
        clk_n(1);
        chk("forced", 32'h301, 32'(drive));
        chk("forced leds", 32'h401, 32'(leds));
        clk_n(2);
        chk("fail irq", 32'h1, 32'(irq));
        cpu.rd(relay_wd_pkg::ADDR_STATUS, v);
        chk("status", 32'h3, v);
        // With no beat the timer rests at its last count.
        cpu.rd(relay_wd_pkg::ADDR_TIMER, v);
        chk("timer sat", 32'(FC - 1), v);
        cpu.wr(A_CTRL, 32'h3fe);
        clk_n(2);
        chk("latched drive", 32'h300, 32'(drive));
        chk("latched", 32'h1, 32'(fail));
        do_reset();
        chk("reset clears", 32'h0, 32'(fail));
    endtask

    // Main sequence.
    initial begin
        i_rst = 1'b1;
        num_errors = 0;
        num_checks = 0;
        t_map();
        t_irq();
        t_alive();
        t_fail();
        final_report();
    end

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge i_clk);
        num_errors++;
        final_report();
    end
endmodule // testbench
`default_nettype wire
